/* File: verilog/mda_top.sv */
`timescale 1ns/100ps
// What this block does
// - hour counters wrap 65535 back to 0
// - each wrap bumps that counter's carry count
// - running hours advance only while running
// - sub-hour time lost at power-on reset
// - write 0 clears run hours; reads 9999
// - energy integrated, reported values updated hourly
// - write 0 clears both energy accumulators
// - panel energy auto-ranges 0.01/0.1/1 kWh
// - limit code 10 caps 9999, 9999 caps 65535
// - fieldbus energy in kWh and 0.01 kWh
// - panel value above 9999 shows dashes
// - panel hours: 0.001 per hour, to 65.53
// - digit select 0 truncates to integer
// - digit select 1 keeps tenths only
// - hours and energy ignore digit select
// - code 100: set freq stopped, Hz flickers
// - stop frequency is limited and jump-adjusted
// - fault freq, shutoff as stop, tuning overrides
// - code 55 lights terminal segments, centre always
// - third page shows selection; set key steps
// - holding set key 1s copies page to first_page, drives no output
// - thermal and loop monitors in 0.1 steps
// - 100% thermal trips motor or drive fault
module mda_top #(
    parameter logic [39:0] HOUR_CYCLES = mda_pkg::HOUR_CYCLES,
    parameter logic [26:0] HOLD_CYCLES = mda_pkg::HOLD_CYCLES,
    parameter logic [24:0] FLICK_CYCLES = mda_pkg::FLICK_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic set_key_i,
    input wire logic output_shutoff_input_i,
    input wire logic open_collector_output_i,
    input wire logic remote_status_bit_a_i,
    input wire logic remote_status_bit_b_i,
    input wire logic remote_status_bit_c_i,
    input wire logic running_i,
    input wire logic fault_i,
    input wire logic tuning_i,
    input wire logic [15:0] tune_status_i,
    input wire logic [15:0] fault_code_i,
    input wire logic [15:0] out_freq_i,
    input wire logic [15:0] out_current_i,
    input wire logic [15:0] out_voltage_i,
    input wire logic [15:0] out_power_i,
    input wire logic [15:0] set_freq_i,
    input wire logic [15:0] freq_max_i,
    input wire logic [15:0] freq_min_i,
    input wire logic [15:0] jump_lo_i,
    input wire logic [15:0] jump_hi_i,
    input wire logic [15:0] motor_heat_i,
    input wire logic [15:0] drive_heat_i,
    input wire logic [15:0] loop_set_i,
    input wire logic [15:0] loop_meas_i,
    input wire logic [15:0] loop_dev_i,
    input wire logic trip_clear_i,
    input wire logic [7:0] main_display_select_i,
    input wire logic [15:0] decimal_digit_select_i,
    input wire logic run_hours_clear_wr_i,
    input wire logic energy_clear_and_limit_wr_i,
    input wire logic [15:0] param_wdata_i,
    output logic [13:0] panel_digits_o,
    output logic [1:0] panel_point_o,
    output logic panel_dashes_o,
    output logic hz_led_o,
    output logic [3:0] panel_segments_o,
    output logic [1:0] panel_page_o,
    output logic [15:0] power_on_hours_o,
    output logic [15:0] run_hours_o,
    output logic [15:0] power_on_hours_carry_count_o,
    output logic [15:0] run_hours_carry_count_o,
    output logic [15:0] run_hours_clear_rd_o,
    output logic [15:0] energy_clear_and_limit_rd_o,
    output logic [15:0] comm_energy_o,
    output logic [31:0] comm_energy2_o,
    output logic motor_overload_fault_o,
    output logic drive_overload_fault_o
);
    typedef struct packed {
        logic [mda_pkg::PIN_N-1:0] sync1;
        logic [mda_pkg::PIN_N-1:0] sync2;
        logic [26:0] hold_cnt;
        logic hold_done;
        mda_pkg::mda_page_t page;
        mda_pkg::mda_page_t first_page;
        logic [39:0] on_sub;
        logic [39:0] run_sub;
        logic [15:0] on_hours;
        logic [15:0] run_hours;
        logic [15:0] on_carry;
        logic [15:0] run_carry;
        logic [39:0] frac;
        logic [22:0] e_hid;
        logic [31:0] e2_hid;
        logic [22:0] e_rep;
        logic [31:0] e2_rep;
        logic [15:0] limit;
        logic fault_prev;
        logic [15:0] fault_freq;
        logic motor_trip;
        logic drive_trip;
        logic [24:0] flick_cnt;
        logic flick;
        logic [13:0] digits;
        logic [1:0] point;
        logic dashes;
        logic hz_led;
        logic [3:0] seg;
        logic [15:0] comm_e;
        logic [31:0] comm_e2;
    } mda_state_t;

    mda_state_t st_q;
    mda_state_t st_d;
    mda_fmt_if fi ();
    logic [mda_pkg::PIN_N-1:0] pins;
    logic on_tick;
    logic run_tick;
    logic run_clr;
    logic e_clr;
    logic e_step;
    logic stopped;
    logic key;

    // frequency that would be output at start: limits, then jump band
    function automatic logic [15:0] limit_freq(input logic [15:0] f, input logic [15:0] fmax,
                                               input logic [15:0] fmin, input logic [15:0] jlo,
                                               input logic [15:0] jhi);
        logic [15:0] r;
        r = f;
        if (r > fmax) begin
            r = fmax;
        end
        if (r < fmin) begin
            r = fmin;
        end
        if (r > jlo && r < jhi) begin
            r = jlo;
        end
        return r;
    endfunction

    assign pins = {remote_status_bit_c_i, remote_status_bit_b_i, remote_status_bit_a_i,
                   open_collector_output_i, output_shutoff_input_i, set_key_i};
    assign key = st_q.sync2[mda_pkg::PIN_KEY];
    // shutoff shows the same values as a stop
    assign stopped = !running_i || st_q.sync2[mda_pkg::PIN_SHUTOFF];
    assign on_tick = (st_q.on_sub == HOUR_CYCLES - 40'h00_0000_0001);
    assign run_tick = running_i && (st_q.run_sub == HOUR_CYCLES - 40'h00_0000_0001);
    assign run_clr = run_hours_clear_wr_i && (param_wdata_i == mda_pkg::CODE_CLEAR);
    assign e_clr = energy_clear_and_limit_wr_i && (param_wdata_i == mda_pkg::CODE_CLEAR);
    assign e_step = (st_q.frac + 40'(out_power_i) >= HOUR_CYCLES);

    mda_fmt u_fmt (
        .f(fi.fmt)
    );

    // operand for the panel formatter, chosen from the page and selection
    always_comb begin
        fi.raw = 32'h0000_0000;
        fi.decimals = 2'd2;
        fi.exempt = 1'b0;
        fi.auto_range = 1'b0;
        fi.digit_sel = decimal_digit_select_i;
        case (st_q.page)
            mda_pkg::PG_FREQ: begin
                if (fault_i) begin
                    fi.raw = 32'(st_q.fault_freq);
                end else if (main_display_select_i == mda_pkg::SEL_SET_STOP && stopped) begin
                    fi.raw = 32'(limit_freq(set_freq_i, freq_max_i, freq_min_i, jump_lo_i,
                                            jump_hi_i));
                end else begin
                    fi.raw = 32'(out_freq_i);
                end
            end
            mda_pkg::PG_CURR: begin
                fi.raw = 32'(out_current_i);
            end
            mda_pkg::PG_THIRD: begin
                // third position carries the selected monitor
                if (main_display_select_i == mda_pkg::SEL_ON_HOURS) begin
                    fi.raw = 32'(st_q.on_hours / mda_pkg::HOUR_DIV);
                    fi.exempt = 1'b1;
                end else if (main_display_select_i == mda_pkg::SEL_RUN_HOURS) begin
                    fi.raw = 32'(st_q.run_hours / mda_pkg::HOUR_DIV);
                    fi.exempt = 1'b1;
                end else if (main_display_select_i == mda_pkg::SEL_ENERGY) begin
                    fi.raw = 32'(st_q.e_rep);
                    fi.exempt = 1'b1;
                    fi.auto_range = 1'b1;
                end else if (main_display_select_i == mda_pkg::SEL_SET_RAW) begin
                    fi.raw = 32'(set_freq_i);
                end else if (main_display_select_i == mda_pkg::SEL_MOTOR_HEAT) begin
                    fi.raw = 32'(motor_heat_i);
                    fi.decimals = 2'd1;
                end else if (main_display_select_i == mda_pkg::SEL_DRIVE_HEAT) begin
                    fi.raw = 32'(drive_heat_i);
                    fi.decimals = 2'd1;
                end else if (main_display_select_i == mda_pkg::SEL_LOOP_SET) begin
                    fi.raw = 32'(loop_set_i);
                    fi.decimals = 2'd1;
                end else if (main_display_select_i == mda_pkg::SEL_LOOP_MEAS) begin
                    fi.raw = 32'(loop_meas_i);
                    fi.decimals = 2'd1;
                end else if (main_display_select_i == mda_pkg::SEL_LOOP_DEV) begin
                    fi.raw = 32'(loop_dev_i);
                    fi.decimals = 2'd1;
                end else begin
                    fi.raw = 32'(out_voltage_i);
                    fi.decimals = 2'd1;
                end
            end
            default: begin
                fi.raw = 32'(fault_code_i);
                fi.decimals = 2'd0;
            end
        endcase
    end

    // next state of the whole block
    always_comb begin
        st_d = st_q;
        st_d.sync1 = pins;
        st_d.sync2 = st_q.sync1;
        // set key: short press steps the page, a 1 s hold copies the page to first_page
        if (key) begin
            if (st_q.hold_cnt == HOLD_CYCLES - 27'h000_0001) begin
                st_d.first_page = st_q.page;
                st_d.hold_done = 1'b1;
            end else if (!st_q.hold_done) begin
                st_d.hold_cnt = st_q.hold_cnt + 27'h000_0001;
            end
        end else begin
            if (st_q.hold_cnt != 27'h000_0000 && !st_q.hold_done) begin
                st_d.page = mda_pkg::mda_page_t'(st_q.page + 2'd1);
            end
            st_d.hold_cnt = 27'h000_0000;
            st_d.hold_done = 1'b0;
        end
        // sub-hour counts live only in flops, so a reset drops them
        st_d.on_sub = on_tick ? 40'h00_0000_0000 : st_q.on_sub + 40'h00_0000_0001;
        if (on_tick) begin
            st_d.on_hours = st_q.on_hours + 16'h0001;
            if (st_q.on_hours == mda_pkg::HOURS_MAX) begin
                st_d.on_carry = st_q.on_carry + 16'h0001;
            end
        end
        if (running_i) begin
            st_d.run_sub = run_tick ? 40'h00_0000_0000 : st_q.run_sub + 40'h00_0000_0001;
        end
        if (run_clr) begin
            st_d.run_hours = 16'h0000;
        end else if (run_tick) begin
            st_d.run_hours = st_q.run_hours + 16'h0001;
        end
        if (run_tick && st_q.run_hours == mda_pkg::HOURS_MAX && !run_clr) begin
            st_d.run_carry = st_q.run_carry + 16'h0001;
        end
        // energy: power in 0.01 kW summed per cycle, one 0.01 kWh per hour of cycles
        st_d.frac = e_step ? st_q.frac + 40'(out_power_i) - HOUR_CYCLES
                           : st_q.frac + 40'(out_power_i);
        if (e_step) begin
            if (st_q.e_hid != mda_pkg::ENERGY_MAX) begin
                st_d.e_hid = st_q.e_hid + 23'h00_0001;
            end
            st_d.e2_hid = st_q.e2_hid + 32'h0000_0001;
        end
        if (on_tick) begin
            st_d.e_rep = st_q.e_hid;
            st_d.e2_rep = st_q.e2_hid;
        end
        if (e_clr) begin
            st_d.e_hid = 23'h00_0000;
            st_d.e2_hid = 32'h0000_0000;
            st_d.e_rep = 23'h00_0000;
            st_d.e2_rep = 32'h0000_0000;
            st_d.frac = 40'h00_0000_0000;
        end
        if (energy_clear_and_limit_wr_i && (param_wdata_i == mda_pkg::CODE_LIMIT_SMALL ||
                                            param_wdata_i == mda_pkg::CODE_NOFUNC)) begin
            st_d.limit = param_wdata_i;
        end
        // fieldbus copies, main one in kWh and capped by the limit code
        st_d.comm_e = 16'(st_q.e_rep / mda_pkg::CENTI_PER_UNIT);
        if (st_q.limit == mda_pkg::CODE_LIMIT_SMALL &&
            st_d.comm_e > mda_pkg::COMM_CAP_SMALL) begin
            st_d.comm_e = mda_pkg::COMM_CAP_SMALL;
        end
        st_d.comm_e2 = st_q.e2_rep;
        // frequency held from the moment a fault appears
        st_d.fault_prev = fault_i;
        if (fault_i && !st_q.fault_prev) begin
            st_d.fault_freq = out_freq_i;
        end
        // overload trips latch until cleared
        if (trip_clear_i) begin
            st_d.motor_trip = 1'b0;
            st_d.drive_trip = 1'b0;
        end
        if (motor_heat_i >= mda_pkg::THERM_TRIP) begin
            st_d.motor_trip = 1'b1;
        end
        if (drive_heat_i >= mda_pkg::THERM_TRIP) begin
            st_d.drive_trip = 1'b1;
        end
        if (st_q.flick_cnt == FLICK_CYCLES - 25'h000_0001) begin
            st_d.flick_cnt = 25'h000_0000;
            st_d.flick = !st_q.flick;
        end else begin
            st_d.flick_cnt = st_q.flick_cnt + 25'h000_0001;
        end
        st_d.hz_led = (st_q.page == mda_pkg::PG_FREQ) &&
                      !(main_display_select_i == mda_pkg::SEL_SET_STOP && stopped &&
                        !fault_i && st_q.flick);
        // terminal pattern, centre bar fixed on
        st_d.seg = 4'h0;
        if (main_display_select_i == mda_pkg::SEL_TERMINALS) begin
            st_d.seg = {1'b1, st_q.sync2[mda_pkg::PIN_C], st_q.sync2[mda_pkg::PIN_B],
                        st_q.sync2[mda_pkg::PIN_A] | st_q.sync2[mda_pkg::PIN_OC]};
        end
        // tuning status outranks every other panel value
        if (tuning_i) begin
            st_d.digits = tune_status_i[13:0];
            st_d.point = 2'd0;
            st_d.dashes = 1'b0;
        end else begin
            st_d.digits = fi.digits;
            st_d.point = fi.point;
            st_d.dashes = fi.dashes;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= '0;
            st_q.limit <= mda_pkg::CODE_NOFUNC;
        end else begin
            st_q <= st_d;
        end
    end

    assign panel_digits_o = st_q.digits;
    assign panel_point_o = st_q.point;
    assign panel_dashes_o = st_q.dashes;
    assign hz_led_o = st_q.hz_led;
    assign panel_segments_o = st_q.seg;
    assign panel_page_o = st_q.page;
    assign power_on_hours_o = st_q.on_hours;
    assign run_hours_o = st_q.run_hours;
    assign power_on_hours_carry_count_o = st_q.on_carry;
    assign run_hours_carry_count_o = st_q.run_carry;
    assign run_hours_clear_rd_o = mda_pkg::CODE_NOFUNC;
    assign energy_clear_and_limit_rd_o = st_q.limit;
    assign comm_energy_o = st_q.comm_e;
    assign comm_energy2_o = st_q.comm_e2;
    assign motor_overload_fault_o = st_q.motor_trip;
    assign drive_overload_fault_o = st_q.drive_trip;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    a_run_stop_hold: assert property (!running_i && !run_clr |=> $stable(st_q.run_sub) && $stable(st_q.run_hours)) else $error("run time moved while stopped");
    a_run_wrap_carry: assert property (run_tick && st_q.run_hours == mda_pkg::HOURS_MAX && !run_clr |=> st_q.run_hours == 16'h0000 && st_q.run_carry == $past(st_q.run_carry) + 16'h0001) else $error("run hour wrap lost");
    a_run_clear_zero: assert property (run_clr |=> run_hours_o == 16'h0000) else $error("run hours not cleared");
    a_energy_hourly: assert property (!on_tick && !e_clr |=> $stable(st_q.e_rep) && $stable(st_q.e2_rep)) else $error("energy report moved off the hour");
    a_energy_clear: assert property (e_clr |=> st_q.e_hid == 23'h00_0000 && st_q.e2_hid == 32'h0000_0000 ##1 comm_energy2_o == 32'h0000_0000) else $error("energy clear incomplete");
    a_comm_cap_small: assert property (st_q.limit == mda_pkg::CODE_LIMIT_SMALL |=> comm_energy_o <= mda_pkg::COMM_CAP_SMALL) else $error("comm energy over small cap");
    a_motor_trip_set: assert property (motor_heat_i >= mda_pkg::THERM_TRIP |=> motor_overload_fault_o) else $error("motor overload not tripped");
    a_tune_priority: assert property (tuning_i |=> panel_digits_o == $past(tune_status_i[13:0]) && !panel_dashes_o) else $error("tuning status not shown");
    a_term_centre: assert property (main_display_select_i == mda_pkg::SEL_TERMINALS |=> panel_segments_o[3]) else $error("centre segment dark");
    a_dash_blank: assert property (panel_dashes_o |-> panel_digits_o == 14'h0000) else $error("dashes with digits");
endmodule // mda_top

/* File: verilog/mda_pkg.sv */
package mda_pkg;
    // clock and time base
    localparam logic [31:0] CLK_HZ = 32'h0773_5940;
    localparam logic [31:0] HOUR_S = 32'h0000_0e10;
    localparam logic [31:0] HOLD_MS = 32'h0000_03e8;
    localparam logic [31:0] FLICK_MS = 32'h0000_00fa;
    localparam logic [31:0] MS_PER_S = 32'h0000_03e8;
    localparam logic [39:0] HOUR_CYCLES = 40'(HOUR_S) * 40'(CLK_HZ);
    localparam logic [26:0] HOLD_CYCLES = 27'(CLK_HZ / MS_PER_S * HOLD_MS);
    localparam logic [24:0] FLICK_CYCLES = 25'(CLK_HZ / MS_PER_S * FLICK_MS);

    // counter limits and parameter codes
    localparam logic [15:0] HOURS_MAX = 16'hffff;
    localparam logic [15:0] CODE_CLEAR = 16'h0000;
    localparam logic [15:0] CODE_NOFUNC = 16'h270f;
    localparam logic [15:0] CODE_LIMIT_SMALL = 16'h000a;
    localparam logic [15:0] COMM_CAP_SMALL = 16'h270f;
    localparam logic [15:0] COMM_CAP_BIG = 16'hffff;
    localparam logic [22:0] ENERGY_MAX = 23'h63_ffff;
    localparam logic [22:0] CENTI_PER_UNIT = 23'h00_0064;
    localparam logic [15:0] THERM_TRIP = 16'h03e8;
    localparam logic [31:0] PANEL_MAX = 32'h0000_270f;
    localparam logic [15:0] HOUR_DIV = 16'h000a;

    // decimal digit selection
    localparam logic [15:0] DSEL_INT = 16'h0000;
    localparam logic [15:0] DSEL_TENTH = 16'h0001;

    // display selection codes
    localparam logic [7:0] SEL_CYCLE = 8'h00;
    localparam logic [7:0] SEL_SET_RAW = 8'h05;
    localparam logic [7:0] SEL_ON_HOURS = 8'h14;
    localparam logic [7:0] SEL_RUN_HOURS = 8'h17;
    localparam logic [7:0] SEL_ENERGY = 8'h19;
    localparam logic [7:0] SEL_LOOP_SET = 8'h34;
    localparam logic [7:0] SEL_LOOP_MEAS = 8'h35;
    localparam logic [7:0] SEL_LOOP_DEV = 8'h36;
    localparam logic [7:0] SEL_TERMINALS = 8'h37;
    localparam logic [7:0] SEL_MOTOR_HEAT = 8'h3d;
    localparam logic [7:0] SEL_DRIVE_HEAT = 8'h3e;
    localparam logic [7:0] SEL_SET_STOP = 8'h64;

    // pin synchroniser lanes
    localparam int PIN_KEY = 0;
    localparam int PIN_SHUTOFF = 1;
    localparam int PIN_OC = 2;
    localparam int PIN_A = 3;
    localparam int PIN_B = 4;
    localparam int PIN_C = 5;
    localparam int PIN_N = 6;

    typedef enum logic [1:0] {
        PG_FREQ,
        PG_CURR,
        PG_THIRD,
        PG_FAULT
    } mda_page_t;
endpackage

/* File: verilog/mda_fmt_if.sv */
`timescale 1ns/100ps
interface mda_fmt_if;
    logic [31:0] raw;
    logic [1:0] decimals;
    logic exempt;
    logic auto_range;
    logic [15:0] digit_sel;
    logic [13:0] digits;
    logic [1:0] point;
    logic dashes;

    modport user (output raw, decimals, exempt, auto_range, digit_sel,
                  input digits, point, dashes);
    modport fmt (input raw, decimals, exempt, auto_range, digit_sel,
                 output digits, point, dashes);
endinterface

/* File: verilog/mda_fmt.sv */
`timescale 1ns/100ps
module mda_fmt (
    mda_fmt_if.fmt f
);
    logic [31:0] v;
    logic [1:0] d;

    // decimal reduction, then auto-ranging, then overflow dashes
    always_comb begin
        v = f.raw;
        d = f.decimals;
        if (!f.exempt) begin
            if (f.digit_sel == mda_pkg::DSEL_INT && d != 2'd0) begin
                v = (d == 2'd2) ? v / 32'h0000_0064 : v / 32'h0000_000a;
                d = 2'd0;
            end else if (f.digit_sel == mda_pkg::DSEL_TENTH && d == 2'd2) begin
                v = v / 32'h0000_000a;
                d = 2'd1;
            end
        end
        // energy steps 0.01 -> 0.1 -> 1 as the value grows
        if (f.auto_range && v > mda_pkg::PANEL_MAX && d != 2'd0) begin
            v = v / 32'h0000_000a;
            d = d - 2'd1;
        end
        if (f.auto_range && v > mda_pkg::PANEL_MAX && d != 2'd0) begin
            v = v / 32'h0000_000a;
            d = d - 2'd1;
        end
        f.dashes = (v > mda_pkg::PANEL_MAX);
        f.digits = f.dashes ? 14'h0000 : v[13:0];
        f.point = d;
    end
endmodule // mda_fmt

/* File: verif/mda_master.sv */
`timescale 1ns/100ps
// fieldbus master model: parameter writes as one-cycle pulses
module mda_master (
    input wire logic clk_i,
    output logic run_wr_o,
    output logic nrg_wr_o,
    output logic [15:0] data_o
);
    initial begin
        run_wr_o = 1'b0;
        nrg_wr_o = 1'b0;
        data_o = 16'h0000;
    end
    // strobe and data held across the taking edge, then data goes stale on purpose
    task automatic put(input logic nrg, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        run_wr_o = ~nrg;
        nrg_wr_o = nrg;
        data_o = d;
        @(posedge clk_i);
        #1;
        run_wr_o = 1'b0;
        nrg_wr_o = 1'b0;
        data_o = ~d;
    endtask
endmodule // mda_master

/* File: verif/test_monitor_display_accumulators.sv */
`timescale 1ns/100ps
module test_monitor_display_accumulators;
    localparam int HC = 20;
    logic clk, rst_n, key, shut, oc, ra, rb, rc_b, run, tun, tclr, rwr, ewr, hb, flt;
    logic [15:0] tst, of, sf, fmx, fmn, pw, mh, dh, dsel, wd, ce, onh, rnh, rcl, elim, onc, rnc;
    logic [15:0] nz = 16'h0000;
    logic [7:0] sel;
    logic [16:0] s;
    logic [13:0] dig;
    logic [1:0] pt, pg;
    logic [3:0] seg;
    logic [31:0] ce2;
    logic dsh, hz, mf, df;
    int errors, samples_checked, cc, e, v, i, n;
    mda_master m (.clk_i(clk), .run_wr_o(rwr), .nrg_wr_o(ewr), .data_o(wd));
    mda_top #(.HOUR_CYCLES(40'h00_0000_0014), .HOLD_CYCLES(27'h000_0004),
        .FLICK_CYCLES(25'h00_0003)) dut_u (.core_clk_i(clk), .rstn_i(rst_n),
        .set_key_i(key), .output_shutoff_input_i(shut), .open_collector_output_i(oc),
        .remote_status_bit_a_i(ra), .remote_status_bit_b_i(rb), .remote_status_bit_c_i(rc_b),
        .running_i(run), .fault_i(flt), .tuning_i(tun), .tune_status_i(tst),
        .fault_code_i(nz), .out_freq_i(of), .out_current_i(nz), .out_voltage_i(~nz),
        .out_power_i(pw), .set_freq_i(sf), .freq_max_i(fmx), .freq_min_i(fmn),
        .jump_lo_i(16'h03e8), .jump_hi_i(16'h044c), .motor_heat_i(mh), .drive_heat_i(dh),
        .loop_set_i(nz), .loop_meas_i(~nz), .loop_dev_i(nz), .trip_clear_i(tclr),
        .main_display_select_i(sel), .decimal_digit_select_i(dsel),
        .run_hours_clear_wr_i(rwr), .energy_clear_and_limit_wr_i(ewr), .param_wdata_i(wd),
        .panel_digits_o(dig), .panel_point_o(pt), .panel_dashes_o(dsh), .hz_led_o(hz),
        .panel_segments_o(seg), .panel_page_o(pg), .power_on_hours_o(onh),
        .run_hours_o(rnh), .power_on_hours_carry_count_o(onc), .run_hours_carry_count_o(rnc),
        .run_hours_clear_rd_o(rcl), .energy_clear_and_limit_rd_o(elim),
        .comm_energy_o(ce), .comm_energy2_o(ce2), .motor_overload_fault_o(mf),
        .drive_overload_fault_o(df));
    // clock, cycle count since reset release, and noise on the unchecked inputs
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk or negedge rst_n) if (!rst_n) cc <= 0; else cc <= cc + 1;
    always @(posedge clk) nz <= #1 nz + 16'h2f1b;
    function automatic logic [15:0] rnd();
        s = {s[15:0], s[16] ^ s[13]};
        return s[15:0];
    endfunction
    task cy(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task rst();
        rst_n = 1'b0;
        cy(8);
        rst_n = 1'b1;
    endtask
    // compare in mid-hour only, so a one-edge phase choice cannot matter
    task hchk();
        while (cc % HC != 10) cy(1);
        chk(onh, cc / HC);
    endtask
    task press();
        key = 1'b1;
        cy(2);
        key = 1'b0;
        cy(5);
    endtask
    // about 10k cycles of tests; a hang is cut well after that
    initial begin
        #320000;
        errors++;
        stop_test();
    end
    initial begin
        {key, shut, oc, ra, rb, rc_b, run, tun, tclr, flt} = 10'h000;
        {tst, of, sf, fmn, pw, mh, dh} = 112'h0;
        fmx = 16'hffff;
        dsel = 16'h270f;
        sel = 8'h00;
        s = 17'h1_25b6;
        errors = 0;
        samples_checked = 0;
        rst();
        run = 1'b1;
        cy(10);
        rst();
        cy(50);
        run = 1'b0;
        hchk();
        chk(rnh, 2);
        cy(30);
        hchk();
        chk(rnh, 2);
        chk(rcl, 16'h270f);
        chk(elim, 16'h270f);
        chk({onc, rnc}, 32'h0);
        m.put(1'b0, 16'h270f);
        cy(1);
        chk(rnh, 2);
        m.put(1'b0, 16'h0000);
        cy(1);
        chk(rnh, 0);
        $display("hours test done");
        // energy and hours monitors live on the third page
        press();
        press();
        // power window at 0.2 kW keeps the fraction fixed: one 0.01 kWh per cycle
        sel = mda_pkg::SEL_ENERGY;
        dsel = 16'h0000;
        e = 0;
        for (i = 0; i < 3; i++) begin
            while (cc % HC != 2) cy(1);
            n = (i == 1) ? 10005 : rnd() % 16;
            pw = 16'h0014;
            cy(n);
            pw = 16'h0000;
            e += n;
            while (cc % HC != 18) cy(1);
            if (i != 1) chk(ce2, e - n);
            hchk();
            chk(ce2, e);
            chk(ce, e / 100);
            chk(dig, e < 10000 ? e : e / 10);
            chk(pt, e < 10000 ? 2 : 1);
        end
        m.put(1'b1, 16'h0000);
        cy(2);
        chk(ce2, 0);
        chk(ce, 0);
        m.put(1'b1, 16'h000a);
        cy(1);
        chk(elim, 16'h000a);
        m.put(1'b1, 16'h0005);
        cy(1);
        chk(elim, 16'h000a);
        m.put(1'b1, 16'h270f);
        cy(1);
        chk(elim, 16'h270f);
        sel = mda_pkg::SEL_ON_HOURS;
        hchk();
        chk(dig, cc / HC / 10);
        chk(pt, 2);
        press();
        press();
        $display("energy test done");
        sel = 8'h00;
        for (i = 0; i < 6; i++) begin
            of = (i < 2) ? 16'(9999 + i) : rnd();
            dsel = (i < 2) ? 16'h270f : 16'(i % 2);
            cy(3);
            v = (dsel == 0) ? of / 100 : (dsel == 1) ? of / 10 : of;
            chk(dsh, v > 9999);
            if (v < 10000) chk(dig, v);
            if (v < 10000) chk(pt, dsel > 1 ? 2 : dsel);
        end
        $display("format test done");
        sel = mda_pkg::SEL_SET_STOP;
        dsel = 16'h270f;
        fmx = 16'h1770;
        fmn = 16'h01f4;
        for (i = 0; i < 4; i++) begin
            sf = (i == 0) ? 16'h1b58 : (i == 1) ? 16'h0064 : (i == 2) ? 16'h0bb8 : 16'h0410;
            v = sf > fmx ? fmx : sf < fmn ? fmn : sf;
            if (v > 1000 && v < 1100) v = 1000;
            cy(3);
            chk(dig, v);
        end
        hb = hz;
        cy(3);
        chk(hz, !hb);
        shut = 1'b1;
        run = 1'b1;
        of = 16'h0457;
        cy(4);
        chk(dig, v);
        shut = 1'b0;
        cy(4);
        chk(dig, of);
        chk(hz, 1);
        // frequency caught at the fault edge must ignore later changes
        flt = 1'b1;
        cy(2);
        of = ~of;
        cy(3);
        chk(dig, 16'h0457);
        flt = 1'b0;
        tun = 1'b1;
        tst = rnd() % 10000;
        cy(3);
        chk(dig, tst);
        chk(pt, 0);
        tun = 1'b0;
        $display("frequency test done");
        sel = mda_pkg::SEL_TERMINALS;
        press();
        press();
        chk(pg, 2);
        for (i = 0; i < 4; i++) begin
            {oc, ra, rb, rc_b} = rnd();
            cy(4);
            chk(seg, {1'b1, rc_b, rb, oc | ra});
        end
        sel = mda_pkg::SEL_MOTOR_HEAT;
        mh = 16'h03e7;
        dh = 16'h03e8;
        cy(3);
        chk(dig, 16'h03e7);
        chk(pt, 1);
        chk({mf, df}, 2'b01);
        mh = 16'h03e8;
        cy(3);
        chk(mf, 1);
        {mh, dh} = 32'h0;
        tclr = 1'b1;
        cy(2);
        tclr = 1'b0;
        chk({mf, df}, 2'b00);
        press();
        press();
        chk(pg, 0);
        $display("panel test done");
        stop_test();
    end
endmodule // test_monitor_display_accumulators
